// *** src/cfu_pkg.sv ***
// Purpose: Shared constants and types for the core register and fetch block
// Assumes: 125 MHz core clock, synchronous active-high reset
// Notes: Register select codes are local choices
package cfu_pkg;
  localparam int ADDR_W = 20;
  localparam int WORD_W = 16;
  localparam int SEG_SHIFT = 4;
  localparam int QUEUE_DEPTH = 6;
  localparam int QPTR_W = 3;
  localparam logic [15:0] CODE_SEG_RST = 16'hffff;
  localparam logic [15:0] DATA_SEG_RST = 16'h0000;
  localparam logic [15:0] EXTRA_SEG_RST = 16'h0000;
  localparam logic [15:0] STACK_SEG_RST = 16'h0000;
  localparam logic [15:0] IP_RST = 16'h0000;
  localparam logic [15:0] FLAGS_RST = 16'hf000;

  // Register select: 0..7 general, 8..11 segment, 12 flags, 13 ip
  typedef enum logic [3:0] {
    CFU_R_ACC = 4'h0, CFU_R_COUNT = 4'h1, CFU_R_PORT = 4'h2,
    CFU_R_BASE = 4'h3, CFU_R_STACK = 4'h4, CFU_R_FRAME = 4'h5,
    CFU_R_SRC = 4'h6, CFU_R_DEST = 4'h7, CFU_R_EXTRA = 4'h8,
    CFU_R_CODE = 4'h9, CFU_R_SSEG = 4'ha, CFU_R_DSEG = 4'hb,
    CFU_R_FLAGS = 4'hc, CFU_R_IP = 4'hd
  } cfu_reg_t;

  // Byte-half select for data registers
  typedef enum logic [1:0] {
    CFU_W_WORD = 2'h0, CFU_W_LOW = 2'h1, CFU_W_HIGH = 2'h2
  } cfu_width_t;

  typedef enum logic [1:0] {
    CFU_BS_IDLE = 2'b00, CFU_BS_FETCH = 2'b01, CFU_BS_OPER = 2'b10
  } cfu_bus_state_t;
endpackage

// *** src/cfu_regfile_if.sv ***
// Purpose: Carries register file access between the core and its store
// Assumes: Single clock domain
// Notes: Read data are registered in the store
interface cfu_regfile_if;
  logic we;
  logic [2:0] waddr;
  logic [15:0] wdata;
  logic [1:0] wbe;
  logic [2:0] raddr;
  logic [15:0] rdata;
  modport core (output we, waddr, wdata, wbe, raddr, input rdata);
  modport store (input we, waddr, wdata, wbe, raddr, output rdata);
endinterface

// *** src/cfu_gpr_mem.sv ***
// Purpose: Eight general registers with byte-lane writes
// Assumes: Byte enables come from the core decode
// Notes: Contents are never reset
module cfu_gpr_mem (
  input wire logic clk_i,
  cfu_regfile_if.store rf
);
  logic [15:0] mem [8];
  logic [15:0] rdata;

  // Byte halves written separately; no reset applied
  always_ff @(posedge clk_i) begin
    if (rf.we && rf.wbe[0]) begin
      mem[rf.waddr][7:0] <= rf.wdata[7:0];
    end
    if (rf.we && rf.wbe[1]) begin
      mem[rf.waddr][15:8] <= rf.wdata[15:8];
    end
    rdata <= mem[rf.raddr];
  end

  assign rf.rdata = rdata;
endmodule

// *** src/cfu_core.sv ***
// Purpose: Register set, prefetch queue and address path of the core
// Assumes: Memory answers with mem_ack_i, read data valid alongside it
// Notes: Narrow bus variant fetches one byte per bus cycle; operand accesses still move 16 bits
module cfu_core #(
  parameter bit WIDE_BUS = 1'b1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic op_take_i,
  output logic op_valid_o,
  output logic [7:0] op_byte_o,
  input wire logic jump_i,
  input wire logic [15:0] jump_cs_i,
  input wire logic [15:0] jump_ip_i,
  input wire logic oper_req_i,
  input wire logic oper_we_i,
  input wire logic oper_stack_i,
  input wire logic [1:0] oper_seg_i,
  input wire logic [15:0] oper_off_i,
  input wire logic [15:0] oper_wdata_i,
  output logic oper_done_o,
  output logic [15:0] oper_rdata_o,
  input wire logic reg_we_i,
  input wire logic [3:0] reg_sel_i,
  input wire logic [1:0] reg_width_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic [3:0] reg_rsel_i,
  output logic [15:0] reg_rdata_o,
  input wire logic alu_byte_i,
  input wire logic [1:0] alu_op_i,
  input wire logic [15:0] alu_a_i,
  input wire logic [15:0] alu_b_i,
  output logic [15:0] alu_y_o,
  output logic [15:0] saved_ip_o,
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [19:0] mem_addr_o,
  output logic [15:0] mem_wdata_o,
  input wire logic mem_ack_i,
  input wire logic [15:0] mem_rdata_i
);
  cfu_regfile_if rf ();
  cfu_gpr_mem u_gpr (.clk_i(clk_i), .rf(rf));

  logic [15:0] code_seg, data_seg, extra_seg, stack_seg, flags, ip;
  logic [7:0] queue [cfu_pkg::QUEUE_DEPTH];
  logic [2:0] q_count;
  logic [2:0] q_rd;
  logic [2:0] q_wr;
  logic [3:0] rsel_q;
  cfu_pkg::cfu_bus_state_t bus_state, next_bus_state;

  // Register write decode
  wire is_gpr_w = (reg_sel_i < 4'h8);
  wire is_data_w = (reg_sel_i < 4'h4);
  wire byte_ok = is_data_w && (reg_width_i != cfu_pkg::CFU_W_WORD);
  wire [1:0] wbe = !byte_ok ? 2'b11 :
                   (reg_width_i == cfu_pkg::CFU_W_LOW) ? 2'b01 : 2'b10;
  wire [15:0] wdata_lane = (byte_ok && reg_width_i == cfu_pkg::CFU_W_HIGH)
                           ? {reg_wdata_i[7:0], 8'h00} : reg_wdata_i;
  assign rf.we = reg_we_i && is_gpr_w;
  assign rf.waddr = reg_sel_i[2:0];
  assign rf.wdata = wdata_lane;
  assign rf.wbe = wbe;
  assign rf.raddr = reg_rsel_i[2:0];

  // Queue state
  wire q_empty = (q_count == 3'h0);
  wire [2:0] q_need = WIDE_BUS ? 3'h2 : 3'h1;
  wire q_room = (q_count <= 3'(cfu_pkg::QUEUE_DEPTH) - q_need);
  wire take = op_take_i && !q_empty && !jump_i;
  wire [15:0] fetch_off = ip;

  // Physical address forming
  wire [15:0] seg_pick = oper_stack_i ? stack_seg :
                         (oper_seg_i == 2'h0) ? data_seg :
                         (oper_seg_i == 2'h1) ? extra_seg :
                         (oper_seg_i == 2'h2) ? code_seg : stack_seg;
  wire [19:0] oper_addr = {seg_pick, 4'h0} + {4'h0, oper_off_i};
  wire [19:0] fetch_addr = {code_seg, 4'h0} + {4'h0, fetch_off};
  wire fetch_odd = fetch_off[0];
  wire [2:0] fetch_n = (WIDE_BUS && !fetch_odd) ? 3'h2 : 3'h1;

  // Bus arbitration: operand request first
  always_comb begin
    next_bus_state = bus_state;
    case (bus_state)
      cfu_pkg::CFU_BS_IDLE: begin
        if (oper_req_i) begin
          next_bus_state = cfu_pkg::CFU_BS_OPER;
        end else if (q_room && !jump_i) begin
          next_bus_state = cfu_pkg::CFU_BS_FETCH;
        end
      end
      cfu_pkg::CFU_BS_FETCH: begin
        if (mem_ack_i || jump_i) begin
          next_bus_state = cfu_pkg::CFU_BS_IDLE;
        end
      end
      cfu_pkg::CFU_BS_OPER: begin
        if (mem_ack_i) begin
          next_bus_state = cfu_pkg::CFU_BS_IDLE;
        end
      end
      default: next_bus_state = cfu_pkg::CFU_BS_IDLE;
    endcase
  end

  wire fetch_done = (bus_state == cfu_pkg::CFU_BS_FETCH) && mem_ack_i
                    && !jump_i;
  wire start_oper = (bus_state == cfu_pkg::CFU_BS_IDLE) && oper_req_i;
  wire start_fetch = (bus_state == cfu_pkg::CFU_BS_IDLE) && !oper_req_i
                     && q_room && !jump_i;
  wire [2:0] q_add = fetch_done ? fetch_n : 3'h0;
  wire [2:0] q_sub = take ? 3'h1 : 3'h0;
  wire [7:0] fetch_lo = (WIDE_BUS && fetch_odd) ? mem_rdata_i[15:8]
                                                : mem_rdata_i[7:0];

  // Wrap helper for the queue pointers
  function automatic logic [2:0] q_inc(input logic [2:0] p);
    q_inc = (p == 3'(cfu_pkg::QUEUE_DEPTH - 1)) ? 3'h0 : p + 3'h1;
  endfunction

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_state <= cfu_pkg::CFU_BS_IDLE;
    end else begin
      bus_state <= next_bus_state;
    end
  end

  // Queue storage and pointers
  always_ff @(posedge clk_i) begin
    if (rst_i || jump_i) begin
      q_count <= 3'h0;
      q_rd <= 3'h0;
      q_wr <= 3'h0;
    end else begin
      q_count <= q_count + q_add - q_sub;
      if (take) begin
        q_rd <= q_inc(q_rd);
      end
      if (fetch_done) begin
        queue[q_wr] <= fetch_lo;
        if (fetch_n == 3'h2) begin
          queue[q_inc(q_wr)] <= mem_rdata_i[15:8];
          q_wr <= q_inc(q_inc(q_wr));
        end else begin
          q_wr <= q_inc(q_wr);
        end
      end
    end
  end

  // Segment registers, flags and pointer
  wire seg_w = reg_we_i && !is_gpr_w;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      code_seg <= cfu_pkg::CODE_SEG_RST;
      data_seg <= cfu_pkg::DATA_SEG_RST;
      extra_seg <= cfu_pkg::EXTRA_SEG_RST;
      stack_seg <= cfu_pkg::STACK_SEG_RST;
      flags <= cfu_pkg::FLAGS_RST;
      ip <= cfu_pkg::IP_RST;
    end else begin
      if (jump_i) begin
        code_seg <= jump_cs_i;
        ip <= jump_ip_i;
      end else begin
        if (fetch_done) begin
          ip <= ip + 16'(fetch_n);
        end
        if (seg_w && reg_sel_i == cfu_pkg::CFU_R_CODE) begin
          code_seg <= reg_wdata_i;
        end
      end
      if (seg_w && reg_sel_i == cfu_pkg::CFU_R_DSEG) begin
        data_seg <= reg_wdata_i;
      end
      if (seg_w && reg_sel_i == cfu_pkg::CFU_R_EXTRA) begin
        extra_seg <= reg_wdata_i;
      end
      if (seg_w && reg_sel_i == cfu_pkg::CFU_R_SSEG) begin
        stack_seg <= reg_wdata_i;
      end
      if (seg_w && reg_sel_i == cfu_pkg::CFU_R_FLAGS) begin
        flags <= reg_wdata_i;
      end
    end
  end

  // Pointer value saved on the stack: next byte to execute
  wire [15:0] exec_ip = ip - 16'(q_count);

  // ALU: byte or word operands
  wire [15:0] alu_raw = (alu_op_i == 2'h0) ? alu_a_i + alu_b_i :
                        (alu_op_i == 2'h1) ? alu_a_i - alu_b_i :
                        (alu_op_i == 2'h2) ? alu_a_i & alu_b_i :
                        alu_a_i ^ alu_b_i;
  wire [15:0] alu_res = alu_byte_i ? {8'h00, alu_raw[7:0]} : alu_raw;

  wire [15:0] spec_rd = (rsel_q == cfu_pkg::CFU_R_CODE) ? code_seg :
                        (rsel_q == cfu_pkg::CFU_R_DSEG) ? data_seg :
                        (rsel_q == cfu_pkg::CFU_R_EXTRA) ? extra_seg :
                        (rsel_q == cfu_pkg::CFU_R_SSEG) ? stack_seg :
                        (rsel_q == cfu_pkg::CFU_R_FLAGS) ? flags :
                        (rsel_q == cfu_pkg::CFU_R_IP) ? exec_ip : 16'h0000;

  // Registered outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      op_valid_o <= 1'b0;
      op_byte_o <= 8'h00;
      oper_done_o <= 1'b0;
      oper_rdata_o <= 16'h0000;
      mem_req_o <= 1'b0;
      mem_we_o <= 1'b0;
      mem_addr_o <= 20'h0_0000;
      mem_wdata_o <= 16'h0000;
      alu_y_o <= 16'h0000;
      saved_ip_o <= 16'h0000;
      rsel_q <= 4'h0;
    end else begin
      op_valid_o <= take;
      op_byte_o <= queue[q_rd];
      oper_done_o <= (bus_state == cfu_pkg::CFU_BS_OPER) && mem_ack_i;
      if ((bus_state == cfu_pkg::CFU_BS_OPER) && mem_ack_i) begin
        oper_rdata_o <= mem_rdata_i;
      end
      alu_y_o <= alu_res;
      saved_ip_o <= exec_ip;
      rsel_q <= reg_rsel_i;
      if (start_oper) begin
        mem_req_o <= 1'b1;
        mem_we_o <= oper_we_i;
        mem_addr_o <= oper_addr;
        mem_wdata_o <= oper_wdata_i;
      end else if (start_fetch) begin
        mem_req_o <= 1'b1;
        mem_we_o <= 1'b0;
        mem_addr_o <= fetch_addr;
      end else if (mem_ack_i || jump_i) begin
        mem_req_o <= 1'b0;
      end
    end
  end

  assign reg_rdata_o = (rsel_q < 4'h8) ? rf.rdata : spec_rd;

  // Checks
  chk_reset_values: assert property (@(posedge clk_i)
    $fell(rst_i) |-> code_seg == 16'hffff && stack_seg == 16'h0000)
    else $error("segment reset value wrong");
  chk_first_fetch: assert property (@(posedge clk_i)
    $fell(rst_i) |-> fetch_addr == 20'hf_fff0)
    else $error("first fetch address wrong");
  chk_flags_reset: assert property (@(posedge clk_i)
    $fell(rst_i) |-> flags == 16'hf000)
    else $error("flags reset wrong");
  chk_stall_empty: assert property (@(posedge clk_i) disable iff (rst_i)
    q_empty |=> !op_valid_o)
    else $error("byte delivered from empty queue");
  chk_oper_first: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_state == cfu_pkg::CFU_BS_IDLE && oper_req_i
    |=> bus_state == cfu_pkg::CFU_BS_OPER)
    else $error("operand not served first");
  chk_flush_jump: assert property (@(posedge clk_i) disable iff (rst_i)
    jump_i |=> q_count == 3'h0 && ip == $past(jump_ip_i))
    else $error("queue not flushed");
  chk_oper_addr: assert property (@(posedge clk_i) disable iff (rst_i)
    start_oper |=> mem_addr_o == $past(oper_addr) && mem_req_o)
    else $error("operand address wrong");
  chk_stack_seg: assert property (@(posedge clk_i) disable iff (rst_i)
    start_oper && oper_stack_i |=>
    mem_addr_o == {$past(stack_seg), 4'h0} + {4'h0, $past(oper_off_i)})
    else $error("stack not on stack segment");
  chk_prefetch: assert property (@(posedge clk_i) disable iff (rst_i)
    start_fetch |=> mem_req_o && !mem_we_o)
    else $error("prefetch not issued");
  chk_queue_bound: assert property (@(posedge clk_i) disable iff (rst_i)
    q_count <= 3'(cfu_pkg::QUEUE_DEPTH))
    else $error("queue overflow");
  cov_fetch: cover property (@(posedge clk_i) disable iff (rst_i)
    fetch_done);
  cov_take: cover property (@(posedge clk_i) disable iff (rst_i) take);
  cov_oper: cover property (@(posedge clk_i) disable iff (rst_i)
    start_oper);
  cov_jump: cover property (@(posedge clk_i) disable iff (rst_i)
    jump_i && !q_empty);
endmodule

// *** testbench/cfu_mem_model.sv ***
// Purpose: Memory on the core's system bus
// Assumes: Reads return the aligned word holding the address
// Notes: Answers alternate prompt and slow; hold_i stalls them
module cfu_mem_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic hold_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [19:0] addr_i,
  input wire logic [15:0] wdata_i,
  output logic ack_o,
  output logic [15:0] rdata_o,
  output logic [19:0] waddr_o,
  output logic [15:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt;
  logic slow;
  function automatic logic [7:0] fb(input logic [19:0] a);
    return a[7:0] ^ a[15:8] ^ {4'h0, a[19:16]};
  endfunction
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      cnt <= 3'h0;
      slow <= 1'b0;
      rdata_o <= 16'h0000;
    end else if (ack_o) begin
      ack_o <= 1'b0;
      // Released data no longer shows the last word
      rdata_o <= ~rdata_o;
    end else if (req_i && !hold_i) begin
      cnt <= cnt + 3'h1;
      if (cnt == (slow ? 3'h3 : 3'h0)) begin
        ack_o <= 1'b1;
        cnt <= 3'h0;
        slow <= ~slow;
        rdata_o <= {fb({addr_i[19:1], 1'b1}), fb({addr_i[19:1], 1'b0})};
        if (we_i) begin
          waddr_o <= addr_i;
          wdata_o <= wdata_i;
        end
      end
    end
  end
endmodule

// *** testbench/tb_cfu_core.sv ***
// Purpose: Self-checking bench for the core register and fetch block
// Assumes: Wide bus variant, inputs change at the falling edge
// Notes: Expected bytes follow the memory model's address pattern
module tb_cfu_core;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, rst_i = 1'b1, hold = 1'b1, op_take_i = 1'b0;
  logic jump_i = 1'b0, oper_req_i = 1'b0, oper_we_i = 1'b0;
  logic oper_stack_i = 1'b0, reg_we_i = 1'b0, alu_byte_i = 1'b0;
  logic [1:0] oper_seg_i = 2'h0, reg_width_i = 2'h0, alu_op_i = 2'h0;
  logic [3:0] reg_sel_i = 4'h0, reg_rsel_i = 4'h0;
  logic [15:0] jump_cs_i = 16'h0000, jump_ip_i = 16'h0000;
  logic [15:0] oper_off_i = 16'h0000, oper_wdata_i = 16'h0000;
  logic [15:0] reg_wdata_i = 16'h0000, alu_a_i = 16'h0000;
  logic [15:0] alu_b_i = 16'h0000;
  logic op_valid_o, oper_done_o, mem_req_o, mem_we_o, mem_ack_i;
  logic [7:0] op_byte_o;
  logic [15:0] oper_rdata_o, reg_rdata_o, alu_y_o, saved_ip_o;
  logic [15:0] mem_wdata_o, mem_rdata_i, wdata, w;
  logic [19:0] mem_addr_o, waddr;
  logic seen;
  int failures = 0, n_compared = 0;
  logic [3:0] rs[6] = '{4'h9, 4'hb, 4'h8, 4'ha, 4'hc, 4'hd};
  logic [15:0] re[6] = '{16'hffff, 16'h0000, 16'h0000, 16'h0000,
                         16'hf000, 16'h0000};
  logic [2:0] at[5] = '{3'h1, 3'h0, 3'h2, 3'h4, 3'h7};
  logic [15:0] ae[5] = '{16'h0000, 16'h1400, 16'h11fe, 16'h0001, 16'h00fe};

  cfu_core u_cfu_core (.clk_i(clk_i), .rst_i(rst_i), .op_take_i(op_take_i),
    .op_valid_o(op_valid_o), .op_byte_o(op_byte_o), .jump_i(jump_i),
    .jump_cs_i(jump_cs_i), .jump_ip_i(jump_ip_i), .oper_req_i(oper_req_i),
    .oper_we_i(oper_we_i), .oper_stack_i(oper_stack_i),
    .oper_seg_i(oper_seg_i), .oper_off_i(oper_off_i),
    .oper_wdata_i(oper_wdata_i), .oper_done_o(oper_done_o),
    .oper_rdata_o(oper_rdata_o), .reg_we_i(reg_we_i), .reg_sel_i(reg_sel_i),
    .reg_width_i(reg_width_i), .reg_wdata_i(reg_wdata_i),
    .reg_rsel_i(reg_rsel_i), .reg_rdata_o(reg_rdata_o),
    .alu_byte_i(alu_byte_i), .alu_op_i(alu_op_i), .alu_a_i(alu_a_i),
    .alu_b_i(alu_b_i), .alu_y_o(alu_y_o), .saved_ip_o(saved_ip_o),
    .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o), .mem_ack_i(mem_ack_i),
    .mem_rdata_i(mem_rdata_i));
  cfu_mem_model u_cfu_mem_model (.clk_i(clk_i), .rst_i(rst_i),
    .hold_i(hold), .req_i(mem_req_o), .we_i(mem_we_o), .addr_i(mem_addr_o),
    .wdata_i(mem_wdata_o), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i),
    .waddr_o(waddr), .wdata_o(wdata));

  initial begin
    forever #4 clk_i = ~clk_i;
  end

  function automatic logic [7:0] fb(input logic [19:0] a);
    return a[7:0] ^ a[15:8] ^ {4'h0, a[19:16]};
  endfunction
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    if (failures == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic hung();
    failures++;
    print_verdict();
  endtask
  task automatic take_byte(input logic [19:0] a);
    int i;
    op_take_i = 1'b1;
    for (i = 0; i < 300; i++) begin
      @(negedge clk_i);
      if (op_valid_o === 1'b1) break;
    end
    op_take_i = 1'b0;
    if (i == 300) hung();
    chk(op_byte_o, fb(a));
    @(negedge clk_i);
  endtask
  task automatic oper(input logic st, input logic [1:0] sg, input logic we,
                      input logic [15:0] off);
    int i;
    oper_req_i = 1'b1;
    oper_stack_i = st;
    oper_seg_i = sg;
    oper_we_i = we;
    oper_off_i = off;
    for (i = 0; i < 300; i++) begin
      @(negedge clk_i);
      if (oper_done_o === 1'b1) break;
    end
    oper_req_i = 1'b0;
    if (i == 300) hung();
    w = oper_rdata_o;
    @(negedge clk_i);
  endtask
  task automatic wr(input logic [3:0] s, input logic [1:0] wd,
                    input logic [15:0] d);
    reg_we_i = 1'b1;
    reg_sel_i = s;
    reg_width_i = wd;
    reg_wdata_i = d;
    @(negedge clk_i);
    reg_we_i = 1'b0;
    @(negedge clk_i);
  endtask
  task automatic rd(input logic [3:0] s, input logic [15:0] e);
    reg_rsel_i = s;
    @(negedge clk_i);
    chk(reg_rdata_o, e);
  endtask
  task automatic jump(input logic [15:0] cs, input logic [15:0] ip);
    jump_cs_i = cs;
    jump_ip_i = ip;
    jump_i = 1'b1;
    @(negedge clk_i);
    jump_i = 1'b0;
  endtask

  initial begin
    repeat (3) @(negedge clk_i);
    rst_i = 1'b0;
    for (int i = 0; i < 20 && mem_req_o !== 1'b1; i++) @(negedge clk_i);
    chk(mem_req_o, 1'b1);
    chk(mem_addr_o, 20'hf_fff0);
    for (int k = 0; k < 6; k++) rd(rs[k], re[k]);
    hold = 1'b0;
    for (int k = 0; k < 4; k++) take_byte(20'hf_fff0 + k);
    hold = 1'b1;
    op_take_i = 1'b1;
    jump(16'h1234, 16'h0011);
    seen = 1'b0;
    repeat (6) begin
      @(negedge clk_i);
      seen = seen | op_valid_o;
    end
    chk(seen, 1'b0);
    hold = 1'b0;
    take_byte(20'h1_2351);
    take_byte(20'h1_2352);
    @(negedge clk_i);
    chk(saved_ip_o, 16'h0013);
    jump(16'hffff, 16'h0020);
    take_byte(20'h0_0010);
    wr(4'hb, 2'h0, 16'h2000);
    wr(4'ha, 2'h0, 16'h3000);
    oper(1'b0, 2'h0, 1'b0, 16'h0104);
    chk(w, {fb(20'h2_0105), fb(20'h2_0104)});
    oper(1'b0, 2'h1, 1'b0, 16'h0042);
    chk(w, {fb(20'h0_0043), fb(20'h0_0042)});
    oper_wdata_i = 16'hbeef;
    oper(1'b1, 2'h0, 1'b1, 16'h0010);
    chk(waddr, 20'h3_0010);
    chk(wdata, 16'hbeef);
    wr(4'h0, 2'h0, 16'h1234);
    wr(4'h0, 2'h1, 16'h00ab);
    wr(4'h0, 2'h2, 16'h00cd);
    rd(4'h0, 16'hcdab);
    wr(4'h5, 2'h0, 16'h5555);
    wr(4'h5, 2'h1, 16'h00aa);
    rd(4'h5, 16'h00aa);
    alu_a_i = 16'h12ff;
    alu_b_i = 16'h0101;
    for (int k = 0; k < 5; k++) begin
      {alu_op_i, alu_byte_i} = at[k];
      @(negedge clk_i);
      chk(alu_y_o, ae[k]);
    end
    print_verdict();
  end
endmodule
